/* File: src/rtxp_pkg.sv */
package rtxp_pkg;
    // avalon word addresses (register index; byte address is four times the index)
    localparam int ADDR_W = 8;
    localparam logic [7:0] IDX_MODE = 8'h8b;
    localparam logic [7:0] IDX_PRESC = 8'h8c;
    localparam logic [7:0] IDX_MAIN = 8'h8d;
    localparam logic [7:0] IDX_SRC = 8'h8e;
    localparam logic [7:0] IDX_STAT = 8'h8f;
    localparam logic [7:0] IDX_MASK = 8'h90;

    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CNT = 8'hff;
    localparam logic [1:0] RST_SRC = 2'h0;
    localparam logic [1:0] RST_STAT = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h0;

    // mode select codes on {mode_select_bit_one, mode_select_bit_zero}
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_PULSE = 2'h1;

    // count source select codes
    localparam logic [1:0] SRC_F1 = 2'h0;
    localparam logic [1:0] SRC_F8 = 2'h1;
    localparam logic [1:0] SRC_RING = 2'h2;
    localparam logic [1:0] SRC_F2 = 2'h3;
    localparam int F8_DIV_W = 3;

    // status and mask bit positions
    localparam int ST_TIMER = 0;
    localparam int ST_EXT = 1;
    localparam int ST_W = 2;

    // timer_mode_control layout, msb first
    typedef struct packed {
        logic measurement_underflow_flag;
        logic measurement_edge_flag;
        logic mode_select_bit_two;
        logic inverted_output_enable;
        logic count_run_flag;
        logic edge_polarity_select;
        logic mode_select_bit_one;
        logic mode_select_bit_zero;
    } rtxp_mode_s;

    // avalon-mm request group
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
    } rtxp_avs_req_s;

    typedef enum logic [1:0] {
        PEND_IDLE,
        PEND_RELOAD,
        PEND_LOAD,
        PEND_START
    } rtxp_pend_e;
endpackage

/* File: src/rtxp_timer.sv */
`timescale 1ns/100ps
// Behaviour
// - mode bits 00, bit two clear: timer mode
// - edge bit picks rising/falling external interrupt edge
// - rewriting edge bit may set interrupt flag
// - run flag 1 starts, 0 stops counting
// - count source f1, f2, f8 or ring
// - decrement, reload on underflow, keep counting
// - division ratio is (n+1)(m+1)
// - timer request on every main underflow
// - counter reads return live counts
// - stopped write loads reload and counter
// - running write: reload, load, resume over ticks
// - pulse mode toggles output on underflow
// - edge bit sets pulse starting level
// - inverted enable drives complementary pin
// - main counter write restores starting level
module rtxp_timer
(
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // avalon-mm slave
    input wire rtxp_pkg::rtxp_avs_req_s avs_req_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // count source and external interrupt input
    input wire logic ring_oscillator_clock_in,
    input wire logic external_interrupt_one_in,
    // pins
    output logic pulse_output_pin_out,
    output logic pulse_output_pin_oe_n_out,
    output logic complementary_output_pin_out,
    output logic complementary_output_pin_oe_n_out,
    // interrupt
    output logic irq_out
);

////////////////////////////////////////////////////////////////////////////////
// bus slave

logic wait_q;
logic [31:0] rdata_q;
logic [7:0] rdata_d;
logic req_on, wr_done, rd_done;
rtxp_pkg::rtxp_mode_s mode_q;
logic [7:0] presc_q, presc_rl_q, main_q, main_rl_q;
logic [1:0] src_q;
logic [rtxp_pkg::ST_W-1:0] stat_q, mask_q;
assign req_on = avs_req_in.read || avs_req_in.write;
// the access completes on the edge where waitrequest is seen low
assign wr_done = avs_req_in.write && !wait_q;
assign rd_done = avs_req_in.read && !wait_q;

always_comb
begin
    rdata_d = 8'h00;
    case (avs_req_in.address)
        rtxp_pkg::IDX_MODE: rdata_d = mode_q;
        rtxp_pkg::IDX_PRESC: rdata_d = presc_q;
        rtxp_pkg::IDX_MAIN: rdata_d = main_q;
        rtxp_pkg::IDX_SRC: rdata_d = {6'h00, src_q};
        rtxp_pkg::IDX_STAT: rdata_d = {6'h00, stat_q};
        rtxp_pkg::IDX_MASK: rdata_d = {6'h00, mask_q};
        default: rdata_d = 8'h00;
    endcase
end
always_ff @(posedge clk_sys_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        wait_q <= 1'b1;
        rdata_q <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
        if (wait_q && req_on)
        begin
            wait_q <= 1'b0;
            rdata_q <= {24'h00_0000, rdata_d};
        end
        else
            wait_q <= 1'b1;
    end
end

assign avs_readdata_out = rdata_q;
assign avs_waitrequest_out = wait_q;
logic wr_mode, wr_presc, wr_main, rd_stat;
assign wr_mode = wr_done && avs_req_in.address == rtxp_pkg::IDX_MODE;
assign wr_presc = wr_done && avs_req_in.address == rtxp_pkg::IDX_PRESC;
assign wr_main = wr_done && avs_req_in.address == rtxp_pkg::IDX_MAIN;
assign rd_stat = rd_done && avs_req_in.address == rtxp_pkg::IDX_STAT;

////////////////////////////////////////////////////////////////////////////////
// control registers

rtxp_pkg::rtxp_mode_s wmode;
logic pol_change;
assign wmode = rtxp_pkg::rtxp_mode_s'(avs_req_in.writedata[7:0]);
assign pol_change = wr_mode && (wmode.edge_polarity_select != mode_q.edge_polarity_select);

always_ff @(posedge clk_sys_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        mode_q <= rtxp_pkg::RST_MODE;
        src_q <= rtxp_pkg::RST_SRC;
        mask_q <= rtxp_pkg::RST_MASK;
    end
    else if (ce_in)
    begin
        // the run flag is stored as written: 1 runs, 0 stops
        if (wr_mode)
            mode_q <= wmode;
        if (wr_done && avs_req_in.address == rtxp_pkg::IDX_SRC)
            src_q <= avs_req_in.writedata[1:0];
        if (wr_done && avs_req_in.address == rtxp_pkg::IDX_MASK)
            mask_q <= avs_req_in.writedata[rtxp_pkg::ST_W-1:0];
    end
end

logic [1:0] mode_sel;
logic pulse_mode, timer_mode;
assign mode_sel = {mode_q.mode_select_bit_one, mode_q.mode_select_bit_zero};
// bit two set with 00 is the measurement mode, not built here; it counts like timer mode
assign timer_mode = mode_sel == rtxp_pkg::MODE_TIMER && !mode_q.mode_select_bit_two;
assign pulse_mode = mode_sel == rtxp_pkg::MODE_PULSE;

////////////////////////////////////////////////////////////////////////////////
// count source

logic [rtxp_pkg::F8_DIV_W-1:0] f8_q;
logic f2_q, ring_q, src_tick;
always_ff @(posedge clk_sys_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        f2_q <= 1'b0;
        f8_q <= '0;
        ring_q <= 1'b0;
    end
    else if (ce_in)
    begin
        f2_q <= !f2_q;
        f8_q <= f8_q + 1'b1;
        ring_q <= ring_oscillator_clock_in;
    end
end
always_comb
begin
    case (src_q)
        rtxp_pkg::SRC_F1: src_tick = 1'b1;
        rtxp_pkg::SRC_F8: src_tick = &f8_q;
        rtxp_pkg::SRC_RING: src_tick = ring_oscillator_clock_in && !ring_q;
        rtxp_pkg::SRC_F2: src_tick = f2_q;
        default: src_tick = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// prescaler and main counter

rtxp_pkg::rtxp_pend_e pend_q;
logic pend_p_q, pend_m_q;
logic [7:0] pend_pv_q, pend_mv_q;
logic run, cnt_en, presc_uf, main_uf;
assign run = mode_q.count_run_flag;
// no counting from a running write until the third source tick
assign cnt_en = ce_in && run && src_tick && !wr_presc && !wr_main
    && (pend_q == rtxp_pkg::PEND_IDLE || pend_q == rtxp_pkg::PEND_START);
assign presc_uf = cnt_en && presc_q == 8'h00;
assign main_uf = presc_uf && main_q == 8'h00;

always_ff @(posedge clk_sys_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        presc_q <= rtxp_pkg::RST_CNT;
        presc_rl_q <= rtxp_pkg::RST_CNT;
        main_q <= rtxp_pkg::RST_CNT;
        main_rl_q <= rtxp_pkg::RST_CNT;
        pend_q <= rtxp_pkg::PEND_IDLE;
        pend_p_q <= 1'b0;
        pend_m_q <= 1'b0;
        pend_pv_q <= 8'h00;
        pend_mv_q <= 8'h00;
    end
    else if (ce_in)
    begin
        if ((wr_presc || wr_main) && !run)
        begin
            if (wr_presc)
            begin
                presc_rl_q <= avs_req_in.writedata[7:0];
                presc_q <= avs_req_in.writedata[7:0];
            end
            if (wr_main)
            begin
                main_rl_q <= avs_req_in.writedata[7:0];
                main_q <= avs_req_in.writedata[7:0];
            end
        end
        else if (wr_presc || wr_main)
        begin
            // a second write while pending merges and restarts the sequence
            pend_q <= rtxp_pkg::PEND_RELOAD;
            if (wr_presc)
            begin
                pend_p_q <= 1'b1;
                pend_pv_q <= avs_req_in.writedata[7:0];
            end
            if (wr_main)
            begin
                pend_m_q <= 1'b1;
                pend_mv_q <= avs_req_in.writedata[7:0];
            end
        end
        else if (!run && pend_q != rtxp_pkg::PEND_IDLE)
        begin
            // stopped mid-sequence: finish the load at once
            if (pend_p_q)
            begin
                presc_rl_q <= pend_pv_q;
                presc_q <= pend_pv_q;
            end
            if (pend_m_q)
            begin
                main_rl_q <= pend_mv_q;
                main_q <= pend_mv_q;
            end
            pend_q <= rtxp_pkg::PEND_IDLE;
            pend_p_q <= 1'b0;
            pend_m_q <= 1'b0;
        end
        else if (run && src_tick)
        begin
            case (pend_q)
                rtxp_pkg::PEND_RELOAD:
                begin
                    if (pend_p_q)
                        presc_rl_q <= pend_pv_q;
                    if (pend_m_q)
                        main_rl_q <= pend_mv_q;
                    pend_q <= rtxp_pkg::PEND_LOAD;
                end
                rtxp_pkg::PEND_LOAD:
                begin
                    if (pend_p_q)
                        presc_q <= presc_rl_q;
                    if (pend_m_q)
                        main_q <= main_rl_q;
                    pend_q <= rtxp_pkg::PEND_START;
                end
                default:
                begin
                    pend_q <= rtxp_pkg::PEND_IDLE;
                    pend_p_q <= 1'b0;
                    pend_m_q <= 1'b0;
                end
            endcase
            if (cnt_en)
            begin
                if (presc_uf)
                begin
                    presc_q <= presc_rl_q;
                    if (main_uf)
                        main_q <= main_rl_q;
                    else
                        main_q <= main_q - 8'h01;
                end
                else
                    presc_q <= presc_q - 8'h01;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// status, mask and interrupt

logic ext_q, ext_ev;
always_ff @(posedge clk_sys_in or negedge rst_n_in)
begin
    if (!rst_n_in)
        ext_q <= 1'b0;
    else if (ce_in)
        ext_q <= external_interrupt_one_in;
end

// edge select: 0 rising, 1 falling; only while the pin is an input
assign ext_ev = timer_mode && (mode_q.edge_polarity_select
    ? (ext_q && !external_interrupt_one_in)
    : (!ext_q && external_interrupt_one_in));

logic [rtxp_pkg::ST_W-1:0] stat_d, stat_set;
always_comb
begin
    stat_set = '0;
    stat_set[rtxp_pkg::ST_TIMER] = main_uf;
    // a polarity rewrite may look like an edge, so it raises the flag
    stat_set[rtxp_pkg::ST_EXT] = ext_ev || pol_change;
    stat_d = stat_q;
    // clear only what the read reported, so a late event survives
    if (rd_stat)
        stat_d = stat_q & ~rdata_q[rtxp_pkg::ST_W-1:0];
    stat_d = stat_d | stat_set;
end
always_ff @(posedge clk_sys_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        stat_q <= rtxp_pkg::RST_STAT;
        irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
        stat_q <= stat_d;
        irq_out <= |(stat_d & mask_q);
    end
end

////////////////////////////////////////////////////////////////////////////////
// pulse output pins

logic pulse_d;
always_comb
begin
    pulse_d = pulse_output_pin_out;
    // outside pulse mode the output waits at its starting level
    if (!pulse_mode || wr_main)
        pulse_d = mode_q.edge_polarity_select;
    else if (main_uf)
        pulse_d = !pulse_output_pin_out;
end
always_ff @(posedge clk_sys_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        pulse_output_pin_out <= 1'b0;
        pulse_output_pin_oe_n_out <= 1'b1;
        complementary_output_pin_out <= 1'b1;
        complementary_output_pin_oe_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
        pulse_output_pin_out <= pulse_d;
        pulse_output_pin_oe_n_out <= !pulse_mode;
        complementary_output_pin_out <= !pulse_d;
        complementary_output_pin_oe_n_out <= !(pulse_mode && mode_q.inverted_output_enable);
    end
end

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge clk_sys_in); endclocking
default disable iff (!rst_n_in);

a_main_reload: assert property (ce_in && main_uf |=> main_q == $past(main_rl_q))
    else $error("main counter missed reload");
a_main_step: assert property (ce_in && presc_uf && !main_uf |=> main_q == $past(main_q) - 8'h01)
    else $error("main counter did not step");
a_timer_flag: assert property (ce_in && main_uf |=> stat_q[rtxp_pkg::ST_TIMER])
    else $error("underflow flag not set");
a_stop_hold: assert property (ce_in && !run && !wr_presc && pend_q == rtxp_pkg::PEND_IDLE
    |=> $stable(presc_q))
    else $error("prescaler moved while stopped");
a_stopped_write: assert property (ce_in && wr_main && !run
    |=> main_q == main_rl_q && main_q == $past(avs_req_in.writedata[7:0]))
    else $error("stopped write not loaded");
a_pend_reload: assert property (ce_in && run && src_tick && pend_q == rtxp_pkg::PEND_RELOAD
    && pend_m_q && !wr_main && !wr_presc |=> main_rl_q == $past(pend_mv_q))
    else $error("pending reload not written");
a_pulse_toggle: assert property (ce_in && pulse_mode && main_uf && !wr_main
    |=> pulse_output_pin_out != $past(pulse_output_pin_out))
    else $error("pulse did not toggle");
a_pulse_restart: assert property (ce_in && wr_main
    |=> pulse_output_pin_out == $past(mode_q.edge_polarity_select))
    else $error("pulse not at starting level");
a_comp_inverse: assert property (!complementary_output_pin_oe_n_out
    |-> complementary_output_pin_out != pulse_output_pin_out)
    else $error("complementary pin not inverse");
a_ext_edge: assert property (ce_in && ext_ev |=> stat_q[rtxp_pkg::ST_EXT])
    else $error("external edge lost");
a_bus_answer: assert property (req_on && wait_q && ce_in |=> !avs_waitrequest_out ##1 wait_q)
    else $error("bus answer timing wrong");

c_underflow: cover property (main_uf);
c_pulse_run: cover property (pulse_mode && main_uf ##[1:300] main_uf);
c_pend_resume: cover property (pend_q == rtxp_pkg::PEND_START && cnt_en);
c_ext_irq: cover property (ext_ev && mask_q[rtxp_pkg::ST_EXT] ##1 irq_out);

endmodule // rtxp_timer

/* File: tb/reload_timer_pulse_output_bench.sv */
`timescale 1ns/100ps
module reload_timer_pulse_output_bench;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce = 1'b1;
    logic ring_q = 1'b0;
    logic ext_q = 1'b0;
    rtxp_pkg::rtxp_avs_req_s req = '0;
    logic [31:0] rdata;
    logic wait_w;
    logic pulse;
    logic pulse_oe_n;
    logic comp;
    logic comp_oe_n;
    logic irq;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int per;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic [7:0] n;
    logic [7:0] m;

    ////////////////////////////////////////////////////////////////////////////////
    always #4 clk_sys_in = ~clk_sys_in;

    // ring source toggles every cycle, so one rising edge every two cycles
    always @(posedge clk_sys_in) ring_q <= ~ring_q;

    rtxp_timer uut
    (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce),
        .avs_req_in(req),
        .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_w),
        .ring_oscillator_clock_in(ring_q),
        .external_interrupt_one_in(ext_q),
        .pulse_output_pin_out(pulse),
        .pulse_output_pin_oe_n_out(pulse_oe_n),
        .complementary_output_pin_out(comp),
        .complementary_output_pin_oe_n_out(comp_oe_n),
        .irq_out(irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // the whole run needs well under ten thousand cycles
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    // values read right after an edge are the ones that edge sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys_in);
        req.read <= ~w;
        req.write <= w;
        req.address <= a;
        req.writedata <= {24'h0, d};
        do
        begin
            @(posedge clk_sys_in);
        end
        while (wait_w !== 1'b0);
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(what, exp, q);
    endtask

    task automatic toggle_gap(output int c);
        logic l;
        l = pulse;
        c = 0;
        do
        begin
            @(posedge clk_sys_in);
            c++;
        end
        while (pulse === l && c < 5000);
    endtask

    function automatic int exp_gap(input logic [1:0] s, input int pn, input int pm);
        int t;
        case (s)
            rtxp_pkg::SRC_F1: t = 1;
            rtxp_pkg::SRC_F2: t = 2;
            rtxp_pkg::SRC_F8: t = 8;
            default: t = 2;
        endcase
        return t * (pn + 1) * (pm + 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(80));
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rdc("mode", rtxp_pkg::IDX_MODE, {24'h0, rtxp_pkg::RST_MODE});
        rdc("prescaler", rtxp_pkg::IDX_PRESC, {24'h0, rtxp_pkg::RST_CNT});
        rdc("main", rtxp_pkg::IDX_MAIN, {24'h0, rtxp_pkg::RST_CNT});
        rdc("source", rtxp_pkg::IDX_SRC, {30'h0, rtxp_pkg::RST_SRC});
        rdc("status", rtxp_pkg::IDX_STAT, {30'h0, rtxp_pkg::RST_STAT});
        rdc("mask", rtxp_pkg::IDX_MASK, {30'h0, rtxp_pkg::RST_MASK});
        rdc("unmapped", 8'h91, 32'h0);
        wr(rtxp_pkg::IDX_MASK, 8'h01);
        // every count source, first pass with the shortest period
        for (int i = 0; i < 4; i++)
        begin
            n = 8'($urandom % 4);
            m = 8'($urandom % 4);
            if (i == 0)
            begin
                n = 8'h00;
                m = 8'h00;
            end
            wr(rtxp_pkg::IDX_SRC, {6'h0, 2'(i)});
            wr(rtxp_pkg::IDX_PRESC, n);
            wr(rtxp_pkg::IDX_MAIN, m);
            rdc("prescaler load", rtxp_pkg::IDX_PRESC, {24'h0, n});
            rdc("main load", rtxp_pkg::IDX_MAIN, {24'h0, m});
            wr(rtxp_pkg::IDX_MODE, 8'h19);
            toggle_gap(per);
            toggle_gap(per);
            toggle_gap(per);
            check("pulse gap", exp_gap(2'(i), n, m), per);
            check("complement", {31'h0, ~pulse}, {31'h0, comp});
            check("enables", 32'h0, {30'h0, pulse_oe_n, comp_oe_n});
            wr(rtxp_pkg::IDX_MODE, 8'h11);
        end
        check("irq", 32'h1, {31'h0, irq});
        rdc("status", rtxp_pkg::IDX_STAT, 32'h1);
        rdc("status clear", rtxp_pkg::IDX_STAT, 32'h0);
        repeat (2) @(posedge clk_sys_in);
        check("irq clear", 32'h0, {31'h0, irq});
        // live counts while running, frozen counts once stopped
        wr(rtxp_pkg::IDX_SRC, {6'h0, rtxp_pkg::SRC_F1});
        wr(rtxp_pkg::IDX_PRESC, 8'hff);
        wr(rtxp_pkg::IDX_MAIN, 8'hff);
        wr(rtxp_pkg::IDX_MODE, 8'h19);
        bus(1'b0, rtxp_pkg::IDX_PRESC, 8'h00, rd);
        bus(1'b0, rtxp_pkg::IDX_PRESC, 8'h00, rd2);
        // reads are three edges apart, so the live prescaler drops by three
        check("prescaler moving", 32'd3, rd - rd2);
        // clock enable low freezes counters and bus alike
        ce <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        ce <= 1'b1;
        bus(1'b0, rtxp_pkg::IDX_PRESC, 8'h00, rd);
        check("frozen prescaler", 32'd3, rd2 - rd);
        wr(rtxp_pkg::IDX_MODE, 8'h11);
        bus(1'b0, rtxp_pkg::IDX_MAIN, 8'h00, rd);
        bus(1'b0, rtxp_pkg::IDX_MAIN, 8'h00, rd2);
        check("main frozen", rd, rd2);
        // start level, restart on a main write, and a write while running
        // in pulse mode the start level only reaches the pin on a main counter write
        wr(rtxp_pkg::IDX_MODE, 8'h15);
        wr(rtxp_pkg::IDX_PRESC, 8'h01);
        wr(rtxp_pkg::IDX_MAIN, 8'h01);
        repeat (2) @(posedge clk_sys_in);
        check("start level", 32'h1, {31'h0, pulse});
        wr(rtxp_pkg::IDX_MODE, 8'h1d);
        toggle_gap(per);
        wr(rtxp_pkg::IDX_MAIN, 8'h04);
        repeat (2) @(posedge clk_sys_in);
        check("restart level", 32'h1, {31'h0, pulse});
        toggle_gap(per);
        toggle_gap(per);
        check("new gap", 32'd10, per);
        // external interrupt edges in timer mode
        wr(rtxp_pkg::IDX_MODE, 8'h04);
        wr(rtxp_pkg::IDX_MASK, 8'h03);
        wr(rtxp_pkg::IDX_MODE, 8'h00);
        bus(1'b0, rtxp_pkg::IDX_STAT, 8'h00, rd);
        check("polarity flag", 32'h2, rd & 32'h2);
        ext_q <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        check("ext irq", 32'h1, {31'h0, irq});
        rdc("rising edge", rtxp_pkg::IDX_STAT, 32'h2);
        wr(rtxp_pkg::IDX_MODE, 8'h04);
        rdc("polarity rewrite", rtxp_pkg::IDX_STAT, 32'h2);
        ext_q <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        rdc("falling edge", rtxp_pkg::IDX_STAT, 32'h2);
        ext_q <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        rdc("rising ignored", rtxp_pkg::IDX_STAT, 32'h0);
        wrap_up();
    end
endmodule // reload_timer_pulse_output_bench
